// ==== rtl/cvsd_codec.v ====
// half duplex delta codec core and its sample buffer
//
// Summary of operation
// - exactly one serial bit per sampling period
// - decode samples serial input on rising edge
// - encode updates serial output on falling edge
// - select low encodes, high decodes
// - plain text sends quiet pattern, encoding continues
// - force zero resets logic, quiets both outputs
// - quiet pattern alternates one and zero
// - quiet audio steps on falling edges only
// - level flag low at half full scale
// - clamp at three quarters, release below
// - single pole filters, 4 ms syllabic nominal
// - estimate filter time constant 1 ms nominal
// - reconstruction through a 10-bit converter word
// - least step equals two converter levels
// - encode estimate drives audio output too
// - works from 9 to 64 kbps
`include "cvsd_defs.vh"
`default_nettype none

module cvsd_fifo
#(
	parameter W     = 10,
	parameter DEPTH = 32,
	parameter AW    = 5
)
(
	input  wire          clk_in,
	input  wire          rst_n_in,
	input  wire          in_valid_in,
	input  wire [W-1:0]  in_data_in,
	output wire          in_ready_out,
	output wire          out_valid_out,
	output wire [W-1:0]  out_data_out,
	input  wire          out_ready_in
);
	localparam [AW:0] FULL_CNT = DEPTH[AW:0];

	reg  [W-1:0]  mem_q [0:DEPTH-1];
	reg  [AW-1:0] wr_q;
	reg  [AW-1:0] rd_q;
	reg  [AW:0]   cnt_q;
	reg  [AW:0]   cnt_d;
	reg           in_ready_q;
	reg           out_valid_q;
	reg  [W-1:0]  out_data_q;
	wire          push;
	wire          pop;

	assign push = in_valid_in & in_ready_q;
	// the output stage refills whenever words are stored and it is empty or being taken
	assign pop  = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready_in);

	assign in_ready_out  = in_ready_q;
	assign out_valid_out = out_valid_q;
	assign out_data_out  = out_data_q;

	always @*
	begin
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always @(posedge clk_in)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_q        <= {AW{1'b0}};
			rd_q        <= {AW{1'b0}};
			cnt_q       <= {(AW+1){1'b0}};
			in_ready_q  <= 1'b1;
			out_valid_q <= 1'b0;
			out_data_q  <= {W{1'b0}};
		end
		else
		begin
			cnt_q      <= cnt_d;
			in_ready_q <= (cnt_d != FULL_CNT);
			if (push)
			begin
				wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop)
			begin
				rd_q        <= rd_q + {{(AW-1){1'b0}}, 1'b1};
				out_data_q  <= mem_q[rd_q];
				out_valid_q <= 1'b1;
			end
			else if (out_ready_in)
			begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule

module cvsd_codec
(
	input  wire        clk_in,
	input  wire        rst_n_in,
	input  wire        sample_clk_in,
	input  wire        decode_sel_in,
	input  wire        serial_in,
	input  wire        plain_text_quiet_n_in,
	input  wire        force_quiet_reset_n_in,
	input  wire [9:0]  audio_input_in,
	input  wire        sample_ready_in,
	output wire        serial_out,
	output wire [9:0]  reconstructed_audio_out,
	output wire        level_flag_n_out,
	output wire        clamp_active_out,
	output wire        sample_valid_out,
	output wire [9:0]  sample_data_out,
	output wire        sample_room_out,
	output wire        sample_overrun_out
);
	// magnitude of a signed estimate; the clamp keeps it away from the most negative code
	function [15:0] cvsd_mag;
		input [15:0] v;
		begin
			cvsd_mag = v[15] ? (~v + 16'h0001) : v;
		end
	endfunction

	reg         rst_s1_q;
	reg         rst_s2_q;
	wire        rst_n;

	reg  [2:0]  sclk_q;
	reg         din_s1_q;
	reg         din_s2_q;
	reg         mode_s1_q;
	reg         mode_s2_q;
	reg         plain_s1_q;
	reg         plain_s2_q;
	reg         force_s1_q;
	reg         force_s2_q;
	reg  [9:0]  ain_s1_q;
	reg  [9:0]  ain_s2_q;

	reg         rx_bit_q;
	reg  [1:0]  hist_q;
	reg  [11:0] syl_q;
	reg  [15:0] est_q;
	reg         quiet_tog_q;
	reg         serial_q;
	reg  [9:0]  audio_q;
	reg         level_n_q;
	reg         clamp_q;
	reg         push_q;
	reg         overrun_q;

	reg         bit_d;
	reg  [11:0] syl_target;
	reg  [12:0] syl_diff;
	reg  [12:0] syl_step;
	reg  [11:0] syl_d;
	reg  [15:0] step;
	reg  [15:0] leak;
	reg  [15:0] est_sum;
	reg  [15:0] est_d;
	reg         clamp_d;
	reg  [9:0]  audio_d;

	wire        rise;
	wire        fall;
	wire        decoding;
	wire        forced;
	wire        plain;
	wire        fifo_ready;

	// reset is released through two flops; force zero acts through the logic below
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// pins other than sample_ready_in are asynchronous to clk_in; edges are taken from the second and third stages
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q     <= 3'h0;
			din_s1_q   <= 1'b0;
			din_s2_q   <= 1'b0;
			mode_s1_q  <= 1'b0;
			mode_s2_q  <= 1'b0;
			plain_s1_q <= 1'b1;
			plain_s2_q <= 1'b1;
			force_s1_q <= 1'b1;
			force_s2_q <= 1'b1;
			ain_s1_q   <= 10'h000;
			ain_s2_q   <= 10'h000;
		end
		else
		begin
			sclk_q     <= {sclk_q[1:0], sample_clk_in};
			din_s1_q   <= serial_in;
			din_s2_q   <= din_s1_q;
			mode_s1_q  <= decode_sel_in;
			mode_s2_q  <= mode_s1_q;
			plain_s1_q <= plain_text_quiet_n_in;
			plain_s2_q <= plain_s1_q;
			force_s1_q <= force_quiet_reset_n_in;
			force_s2_q <= force_s1_q;
			ain_s1_q   <= audio_input_in;
			ain_s2_q   <= ain_s1_q;
		end
	end

	assign rise     = sclk_q[1] & ~sclk_q[2];
	assign fall     = ~sclk_q[1] & sclk_q[2];
	assign decoding = mode_s2_q;
	assign forced   = ~force_s2_q;
	assign plain    = ~plain_s2_q;

	// one loop step per sampling period; no time base of clk_in is used, so any rate works
	always @*
	begin
		// encode compares the input word with the estimate, decode uses the latched bit
		if (decoding)
		begin
			bit_d = rx_bit_q;
		end
		else
		begin
			bit_d = ($signed(ain_s2_q) > $signed(est_q[15:6]));
		end

		// syllabic filter: single pole toward full or zero on runs of equal bits
		if ((bit_d == hist_q[0]) && (bit_d == hist_q[1]))
		begin
			syl_target = `CVSD_SYL_MAX;
		end
		else
		begin
			syl_target = 12'h000;
		end
		syl_diff = {1'b0, syl_target} - {1'b0, syl_q};
		syl_step = $signed(syl_diff) >>> `CVSD_SYL_SHIFT;
		syl_d    = syl_q + syl_step[11:0];

		// least step is two converter levels in the fractional format
		step = `CVSD_MIN_STEP + {4'h0, syl_q};
		// leaky integrator: time constant of 16 samples at the nominal rate
		leak = $signed(est_q) >>> `CVSD_SE_SHIFT;
		if (bit_d)
		begin
			est_sum = est_q + step - leak;
		end
		else
		begin
			est_sum = est_q - step - leak;
		end

		// hold at the clamp level and stop integrating outward until back inside
		clamp_d = 1'b0;
		est_d   = est_sum;
		if (!est_sum[15] && (est_sum >= `CVSD_CLAMP_LVL))
		begin
			est_d   = `CVSD_CLAMP_LVL;
			clamp_d = 1'b1;
		end
		else if (est_sum[15] && (cvsd_mag(est_sum) >= `CVSD_CLAMP_LVL))
		begin
			est_d   = ~`CVSD_CLAMP_LVL + 16'h0001;
			clamp_d = 1'b1;
		end

		// quieting audio toggles one converter level either side of zero
		if (forced)
		begin
			audio_d = quiet_tog_q ? `CVSD_QUIET_LO : `CVSD_QUIET_HI;
		end
		else
		begin
			audio_d = est_d[15:6];
		end
	end

	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_bit_q    <= 1'b0;
			hist_q      <= 2'h0;
			syl_q       <= 12'h000;
			est_q       <= 16'h0000;
			quiet_tog_q <= 1'b0;
			serial_q    <= 1'b0;
			audio_q     <= 10'h000;
			level_n_q   <= 1'b1;
			clamp_q     <= 1'b0;
			push_q      <= 1'b0;
			overrun_q   <= 1'b0;
		end
		else
		begin
			push_q <= 1'b0;
			if (rise && decoding)
			begin
				rx_bit_q <= din_s2_q;
			end
			if (fall)
			begin
				quiet_tog_q <= ~quiet_tog_q;
				audio_q     <= audio_d;
				push_q      <= 1'b1;
				if (forced)
				begin
					// filters cleared while force zero is held
					hist_q    <= 2'h0;
					syl_q     <= 12'h000;
					est_q     <= 16'h0000;
					clamp_q   <= 1'b0;
					level_n_q <= 1'b1;
					serial_q  <= quiet_tog_q;
				end
				else
				begin
					hist_q    <= {hist_q[0], bit_d};
					syl_q     <= syl_d;
					est_q     <= est_d;
					clamp_q   <= clamp_d;
					level_n_q <= ~(cvsd_mag(est_d) >= `CVSD_AGC_LVL);
					// one new bit per period; quiet pattern in plain text or decode
					if (plain || decoding)
					begin
						serial_q <= quiet_tog_q;
					end
					else
					begin
						serial_q <= bit_d;
					end
				end
			end
			if (forced)
			begin
				overrun_q <= 1'b0;
			end
			else if (push_q && !fifo_ready)
			begin
				// samples cannot wait for a stalled reader; loss is reported instead
				overrun_q <= 1'b1;
			end
		end
	end

	cvsd_fifo
	#(
		.W     (`CVSD_DAC_BITS),
		.DEPTH (`CVSD_FIFO_DEPTH),
		.AW    (`CVSD_FIFO_AW)
	)
	u_fifo
	(
		.clk_in        (clk_in),
		.rst_n_in      (rst_n),
		.in_valid_in   (push_q),
		.in_data_in    (audio_q),
		.in_ready_out  (fifo_ready),
		.out_valid_out (sample_valid_out),
		.out_data_out  (sample_data_out),
		.out_ready_in  (sample_ready_in)
	);

	assign serial_out              = serial_q;
	assign reconstructed_audio_out = audio_q;
	assign level_flag_n_out        = level_n_q;
	assign clamp_active_out        = clamp_q;
	assign sample_room_out         = fifo_ready;
	assign sample_overrun_out      = overrun_q;
endmodule

`default_nettype wire

// ==== rtl/cvsd_defs.vh ====
// constants shared by the delta codec: arithmetic widths, filter constants, thresholds
`ifndef CVSD_DEFS_VH
`define CVSD_DEFS_VH

// converter and estimate arithmetic
`define CVSD_DAC_BITS       10
`define CVSD_FRAC_BITS      6
`define CVSD_EST_W          16
`define CVSD_SYL_W          12
`define CVSD_MIN_STEP       16'h0080
`define CVSD_SYL_MAX        12'h780
`define CVSD_RUN_LEN        3

// filter time constants, in microseconds at the nominal rate in kbps
`define CVSD_NOM_KBPS       16
`define CVSD_SYL_TAU_US     4000
`define CVSD_SE_TAU_US      1000
`define CVSD_SYL_SAMPLES    ((`CVSD_SYL_TAU_US * `CVSD_NOM_KBPS) / 1000)
`define CVSD_SE_SAMPLES     ((`CVSD_SE_TAU_US * `CVSD_NOM_KBPS) / 1000)
// log2 of the sample counts above: 64 and 16 samples
`define CVSD_SYL_SHIFT      6
`define CVSD_SE_SHIFT       4

// thresholds on the estimate magnitude: half and three quarters of full scale
`define CVSD_AGC_LVL        16'h4000
`define CVSD_CLAMP_LVL      16'h6000

// quieting output levels: one converter level above and below zero
`define CVSD_QUIET_HI       10'h001
`define CVSD_QUIET_LO       10'h3ff

// sample buffer
`define CVSD_FIFO_DEPTH     32
`define CVSD_FIFO_AW        5

`endif

// ==== test/cvsd_codec_asserts.sv ====
// port checker for the delta codec, bound to its top module
`default_nettype none
module cvsd_codec_asserts
(
	input wire logic		clk_in,
	input wire logic		rst_n_in,
	input wire logic		sample_clk_in,
	input wire logic		decode_sel_in,
	input wire logic		plain_text_quiet_n_in,
	input wire logic		force_quiet_reset_n_in,
	input wire logic		sample_ready_in,
	input wire logic		serial_out,
	input wire logic [9:0]	reconstructed_audio_out,
	input wire logic		level_flag_n_out,
	input wire logic		clamp_active_out,
	input wire logic		sample_valid_out,
	input wire logic [9:0]	sample_data_out,
	input wire logic		sample_room_out,
	input wire logic		sample_overrun_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic		sp_q;
	logic [7:0]	sc_q;
	logic [7:0]	fc_q;
	logic [7:0]	qc_q;
	wire		fall = sp_q & ~sample_clk_in;
	wire		quiet = ~force_quiet_reset_n_in | ~plain_text_quiet_n_in | decode_sel_in;
	// saturating counters: cycles since a sample clock fall, cycles spent quiet
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sp_q <= 1'b0;
			sc_q <= 8'hff;
			fc_q <= 8'h00;
			qc_q <= 8'h00;
		end
		else
		begin
			sp_q <= sample_clk_in;
			sc_q <= fall ? 8'h00 : sc_q + {7'h00, ~&sc_q};
			fc_q <= force_quiet_reset_n_in ? 8'h00 : fc_q + {7'h00, ~&fc_q};
			qc_q <= quiet ? qc_q + {7'h00, ~&qc_q} : 8'h00;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_serial_fall_only: assert property ($changed(serial_out) |-> sc_q inside {[1:6]})
		else $error("serial output moved away from a sample clock fall");
	a_audio_fall_only: assert property ($changed(reconstructed_audio_out) |-> sc_q inside {[1:6]})
		else $error("audio output moved away from a sample clock fall");
	a_quiet_serial_toggle: assert property (qc_q > 60 && fall |-> ##[1:6] $changed(serial_out))
		else $error("quiet serial pattern did not toggle");
	a_quiet_audio_level: assert property (fc_q > 60 |-> reconstructed_audio_out inside {10'h001, 10'h3ff})
		else $error("forced quiet audio outside the quiet levels");
	a_quiet_audio_step: assert property (fc_q > 60 && fall |-> ##[1:6] $changed(reconstructed_audio_out))
		else $error("forced quiet audio did not step");
	a_level_flag_low: assert property (reconstructed_audio_out inside {[10'h100:10'h2ff]} |-> !level_flag_n_out)
		else $error("level flag high above half scale");
	a_level_flag_high: assert property (!(reconstructed_audio_out inside {[10'h100:10'h300]}) |-> level_flag_n_out)
		else $error("level flag low below half scale");
	a_clamp_range: assert property (!(reconstructed_audio_out inside {[10'h181:10'h27f]}))
		else $error("audio beyond three quarter scale");
	a_clamp_value: assert property (clamp_active_out |-> reconstructed_audio_out inside {10'h180, 10'h280})
		else $error("clamp flag without clamped audio");
	a_fifo_hold: assert property (sample_valid_out && !sample_ready_in && fc_q == 0
		|=> sample_valid_out && $stable(sample_data_out))
		else $error("buffer output dropped while stalled");
	a_overrun_cause: assert property ($rose(sample_overrun_out) |-> !$past(sample_room_out))
		else $error("overrun raised with room left");
	a_overrun_sticky: assert property (sample_overrun_out && fc_q == 0 |=> sample_overrun_out)
		else $error("overrun cleared without force");
	c_clamp: cover property (clamp_active_out);
	c_full: cover property (!sample_room_out);
	c_quiet: cover property (fc_q > 60 && fall);
endmodule
bind cvsd_codec cvsd_codec_asserts u_chk
(
	.clk_in,
	.rst_n_in,
	.sample_clk_in,
	.decode_sel_in,
	.plain_text_quiet_n_in,
	.force_quiet_reset_n_in,
	.sample_ready_in,
	.serial_out,
	.reconstructed_audio_out,
	.level_flag_n_out,
	.clamp_active_out,
	.sample_valid_out,
	.sample_data_out,
	.sample_room_out,
	.sample_overrun_out
);
`default_nettype wire

// ==== test/cvsd_peer.sv ====
// far end of the serial link: sends a repeating bit pattern, logs received bits
`default_nettype none
module cvsd_peer
(
	input wire logic		sample_clk_in,
	input wire logic [7:0]	pattern_in,
	input wire logic		rx_bit_in,
	output logic			tx_bit_out,
	output var logic [7:0]	rx_log_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0]	idx_q = 3'h0;
	initial rx_log_out = 8'h00;
	// bits change on the fall so they are steady around the rise
	always @(negedge sample_clk_in)
	begin
		idx_q <= idx_q + 3'h1;
		rx_log_out <= {rx_log_out[6:0], rx_bit_in};
	end
	assign tx_bit_out = pattern_in[idx_q];
endmodule
`default_nettype wire

// ==== test/cvsd_codec_bench.sv ====
// self-checking bench for the delta codec
`default_nettype none
module cvsd_codec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clk_in = 1'b0;
	logic		rst_n_in = 1'b0;
	logic		sample_clk_in = 1'b0;
	logic		decode_sel_in = 1'b0;
	logic		plain_text_quiet_n_in = 1'b1;
	logic		force_quiet_reset_n_in = 1'b1;
	logic [9:0]	audio_input_in = 10'h000;
	logic		sample_ready_in = 1'b0;
	logic		run = 1'b1;
	logic [7:0]	pat = 8'hff;
	logic [7:0]	rx_log;
	logic [9:0]	a0;
	wire		serial_in;
	wire		serial_out;
	wire [9:0]	reconstructed_audio_out;
	wire		level_flag_n_out;
	wire		clamp_active_out;
	wire		sample_valid_out;
	wire [9:0]	sample_data_out;
	wire		sample_room_out;
	wire		sample_overrun_out;
	int			err_count = 0;
	int			checks = 0;
	int			cyc = 0;
	int			n;
	int			half = 20;
	cvsd_codec dut
	(
		.clk_in,
		.rst_n_in,
		.sample_clk_in,
		.decode_sel_in,
		.serial_in,
		.plain_text_quiet_n_in,
		.force_quiet_reset_n_in,
		.audio_input_in,
		.sample_ready_in,
		.serial_out,
		.reconstructed_audio_out,
		.level_flag_n_out,
		.clamp_active_out,
		.sample_valid_out,
		.sample_data_out,
		.sample_room_out,
		.sample_overrun_out
	);
	cvsd_peer peer
	(
		.sample_clk_in,
		.pattern_in(pat),
		.rx_bit_in(serial_out),
		.tx_bit_out(serial_in),
		.rx_log_out(rx_log)
	);
	always #12.5 clk_in = ~clk_in;
	task automatic complete_run;
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// wait k sample falls, then let the answer settle
	task automatic step(input int k);
		repeat (k)
			@(negedge sample_clk_in);
		repeat (8)
			@(posedge clk_in);
	endtask
	// sample clock of twice half system cycles; it can be paused to drain the buffer or sped up
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (run && cyc % half == half - 1)
			sample_clk_in <= ~sample_clk_in;
		if (cyc == 20000)
		begin
			err_count++;
			complete_run();
		end
	end
	initial
	begin
		repeat (6)
			@(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2)
			@(posedge clk_in);
		check("reset serial", {9'h000, serial_out}, 10'h000);
		check("reset level", {9'h000, level_flag_n_out}, 10'h001);
		audio_input_in <= 10'h1f0;
		step(1);
		check("first step", reconstructed_audio_out, 10'h002);
		check("first bit", {9'h000, serial_out}, 10'h001);
		step(200);
		check("clamped audio", reconstructed_audio_out, 10'h180);
		check("clamp flag", {9'h000, clamp_active_out}, 10'h001);
		check("level flag", {9'h000, level_flag_n_out}, 10'h000);
		check("room", {9'h000, sample_room_out}, 10'h000);
		check("overrun", {9'h000, sample_overrun_out}, 10'h001);
		check("first sample", sample_data_out, 10'h002);
		run <= 1'b0;
		sample_ready_in <= 1'b1;
		n = 0;
		repeat (50)
		begin
			@(negedge clk_in);
			n += sample_valid_out;
		end
		check("drained", n[9:0], 10'h021);
		check("empty", {9'h000, sample_valid_out}, 10'h000);
		@(posedge clk_in);
		run <= 1'b1;
		audio_input_in <= 10'h210;
		step(3);
		check("unclamp", {9'h000, clamp_active_out}, 10'h000);
		check("down bit", {9'h000, serial_out}, 10'h000);
		force_quiet_reset_n_in <= 1'b0;
		step(10);
		a0 = reconstructed_audio_out;
		check("overrun clear", {9'h000, sample_overrun_out}, 10'h000);
		check("quiet bits", {3'h0, rx_log[6:0] ^ rx_log[7:1]}, 10'h07f);
		step(1);
		check("quiet audio", a0 ^ reconstructed_audio_out, 10'h3fe);
		force_quiet_reset_n_in <= 1'b1;
		plain_text_quiet_n_in <= 1'b0;
		audio_input_in <= 10'h1f0;
		step(10);
		check("plain bits", {3'h0, rx_log[6:0] ^ rx_log[7:1]}, 10'h07f);
		a0 = reconstructed_audio_out;
		check("side tone", {9'h000, $signed(a0) > 10'sh001}, 10'h001);
		plain_text_quiet_n_in <= 1'b1;
		decode_sel_in <= 1'b1;
		audio_input_in <= 10'h210;
		step(2);
		a0 = reconstructed_audio_out;
		step(4);
		check("decode up", {9'h000, $signed(reconstructed_audio_out) > $signed(a0)}, 10'h001);
		pat <= 8'h00;
		step(2);
		a0 = reconstructed_audio_out;
		step(4);
		check("decode down", {9'h000, $signed(reconstructed_audio_out) < $signed(a0)}, 10'h001);
		// faster sampling clock: still one bit and one step per period
		half <= 6;
		step(10);
		check("fast bits", {3'h0, rx_log[6:0] ^ rx_log[7:1]}, 10'h07f);
		a0 = reconstructed_audio_out;
		step(4);
		check("fast decode down", {9'h000, $signed(reconstructed_audio_out) < $signed(a0)}, 10'h001);
		complete_run();
	end
endmodule
`default_nettype wire
